// [verilog/cds_defs.svh]
// timing, code and field constants for the compare register and digit scan
`ifndef CDS_DEFS_SVH
`define CDS_DEFS_SVH

`define CDS_CLK_PERIOD_NS 25
// intrinsic interdigit blanking, shortest figure of the documented range
`define CDS_BLANK_NS 5000
`define CDS_BLANK_CYC \
   ((`CDS_BLANK_NS + `CDS_CLK_PERIOD_NS - 1) / `CDS_CLK_PERIOD_NS)
// load command fall to rising digit strobe
`define CDS_LOAD_SETUP_NS 2000
`define CDS_LOAD_SETUP_CYC \
   ((`CDS_LOAD_SETUP_NS + `CDS_CLK_PERIOD_NS - 1) / `CDS_CLK_PERIOD_NS)
// wait after a count edge before the equal flag is judged
`define CDS_EQ_SETTLE_NS 400
`define CDS_EQ_SETTLE_CYC \
   ((`CDS_EQ_SETTLE_NS + `CDS_CLK_PERIOD_NS - 1) / `CDS_CLK_PERIOD_NS)

`define CDS_NUM_DIGITS 6
`define CDS_MSD_IDX 3'h5
`define CDS_LSD_IDX 3'h0
`define CDS_JC_MSD 3'h0
`define CDS_BCD_ZERO 4'h0
`define CDS_SEG_BLANK 7'h00
`define CDS_STROBE_NONE 6'h00
`define CDS_STROBE_ONE 6'h01
`define CDS_SYNC_W 13

`endif

// [verilog/cds_pkg.sv]
// shared types of the compare register and digit scan block
package cds_pkg;

   typedef logic [3:0] cds_bcd_t;
   typedef logic [2:0] cds_jc_t;

   typedef enum logic [2:0] {
      cds_st_preset = 3'h0,
      cds_st_hold = 3'h1,
      cds_st_low = 3'h2,
      cds_st_intr = 3'h3,
      cds_st_show = 3'h4
   } cds_state_e;

endpackage

// [verilog/cds_sync.sv]
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`include "cds_defs.svh"

module cds_sync (
   input wire logic clk,
   input wire logic reset,
   input wire logic [`CDS_SYNC_W-1:0] d,
   output logic [`CDS_SYNC_W-1:0] q
);
   logic [`CDS_SYNC_W-1:0] s1_r;
   logic [`CDS_SYNC_W-1:0] s2_r;
   logic [`CDS_SYNC_W-1:0] s3_r;
   logic [`CDS_SYNC_W-1:0] q_r;

   // a bit changes only once stages two and three agree
   always_ff @(posedge clk) begin
      if (reset) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
         q_r <= '0;
      end else begin
         s1_r <= d;
         s2_r <= s1_r;
         s3_r <= s2_r;
         q_r <= (s2_r & s3_r) | (q_r & (s2_r | s3_r));
      end
   end

   assign q = q_r;
endmodule

// [verilog/cds_cmp_mem.sv]
// six-decade compare register store with registered read port
`timescale 1ns/1ps
`include "cds_defs.svh"

module cds_cmp_mem (
   input wire logic clk,
   input wire logic reset,
   input wire logic wr_en,
   input wire logic [2:0] wr_addr,
   input wire cds_pkg::cds_bcd_t wr_data,
   input wire logic [2:0] rd_addr,
   output cds_pkg::cds_bcd_t rd_data
);
   import cds_pkg::*;

   cds_bcd_t mem_r [0:`CDS_NUM_DIGITS-1];
   cds_bcd_t rd_data_r;

   // no clear path other than reset: a counter clear never reaches here
   always_ff @(posedge clk) begin
      if (reset) begin
         for (int i = 0; i < `CDS_NUM_DIGITS; i++) begin
            mem_r[i] <= `CDS_BCD_ZERO;
         end
      end else if (wr_en) begin
         mem_r[wr_addr] <= wr_data;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         rd_data_r <= `CDS_BCD_ZERO;
      end else begin
         rd_data_r <= mem_r[rd_addr];
      end
   end

   assign rd_data = rd_data_r;
endmodule

// [verilog/cds_scan_top.sv]
// compare register, digit scan and multiplexed display output section
`timescale 1ns/1ps
`include "cds_defs.svh"

// Function
// RQ1: compare register loads one decade per digit strobe, like counter load
// RQ2: register load independent of counter load; counter clear never touches it
// RQ3: display outputs show only latched counter data, never the register
// RQ4: six digit strobes decoded from a divide-by-six Johnson scan counter
// RQ5: scan runs from most to least significant digit, then repeats
// RQ6: preset low holds scan at MSD, blanks segments, shows MSD BCD
// RQ7: after preset release digit six stays on until next scan pulse
// RQ8: segments and all strobes are off during interdigit blanking
// RQ9: leading-zero blanking hits segments only; disable input switches it off
// RQ10: BCD output changes at blanking start, before the next strobe rises
// RQ11: receiver captures BCD output on the rising digit strobe edge
// RQ12: blanking is scan-low dwell plus intrinsic blanking time
// RQ13: without input capacitors, load command falls with scan rising edge
// RQ14: flag inhibit ends only if load fell in blanking 2 us before strobe
// RQ15: count source slows down so flag output times are met
// RQ16: count pulses outlast carry access time when carry is used
// RQ17: equal flag high for one count period when counter matches register
// RQ18: any load inhibits equal until blanking following the load fall
// RQ19: load request caught at strobe rise; data taken at strobe fall
// RQ20: compare register holds six BCD decades, cleared to zero at reset

module cds_scan_top (
   input wire logic clk,
   input wire logic reset,
   input wire logic scan_in,
   input wire logic scan_preset_n,
   input wire logic zero_suppress_disable,
   input wire logic load_counter,
   input wire logic load_register,
   input wire cds_pkg::cds_bcd_t compare_bcd_in,
   input wire cds_pkg::cds_bcd_t counter_bcd_in,
   input wire logic [23:0] latch_data,
   input wire logic [23:0] counter_value,
   input wire logic count_edge,
   output logic [5:0] digit_strobe,
   output logic [6:0] segment,
   output cds_pkg::cds_bcd_t bcd_out,
   output logic equal_flag,
   output logic counter_load_we,
   output logic [2:0] counter_load_digit,
   output cds_pkg::cds_bcd_t counter_load_data
);
   import cds_pkg::*;

   // ==========================================================
   // decoding helpers
   // ==========================================================
   function automatic cds_jc_t jc_next(input cds_jc_t jc);
      jc_next = {jc[1:0], ~jc[2]};
   endfunction

   // johnson code to decade index, index 5 being the MSD
   function automatic logic [2:0] jc_index(input cds_jc_t jc);
      case (jc)
         3'h0: jc_index = 3'h5;
         3'h1: jc_index = 3'h4;
         3'h3: jc_index = 3'h3;
         3'h7: jc_index = 3'h2;
         3'h6: jc_index = 3'h1;
         3'h4: jc_index = 3'h0;
         default: jc_index = `CDS_MSD_IDX;
      endcase
   endfunction

   function automatic cds_bcd_t digit_of(input logic [23:0] data,
                                         input logic [2:0] idx);
      digit_of = data[{idx, 2'h0} +: 4];
   endfunction

   // true when this decade and every higher one are zero; LSD never blanks
   function automatic logic lead_zero(input logic [23:0] data,
                                      input logic [2:0] idx);
      logic z;
      z = 1'b1;
      for (int i = 0; i < `CDS_NUM_DIGITS; i++) begin
         if (i >= int'(idx)) begin
            z = z & (data[i*4 +: 4] == `CDS_BCD_ZERO);
         end
      end
      lead_zero = z & (idx != `CDS_LSD_IDX);
   endfunction

   // segment order g f e d c b a, high means lit; non-BCD codes go dark
   function automatic logic [6:0] seg7(input cds_bcd_t v);
      case (v)
         4'h0: seg7 = 7'h3f;
         4'h1: seg7 = 7'h06;
         4'h2: seg7 = 7'h5b;
         4'h3: seg7 = 7'h4f;
         4'h4: seg7 = 7'h66;
         4'h5: seg7 = 7'h6d;
         4'h6: seg7 = 7'h7d;
         4'h7: seg7 = 7'h07;
         4'h8: seg7 = 7'h7f;
         4'h9: seg7 = 7'h6f;
         default: seg7 = `CDS_SEG_BLANK;
      endcase
   endfunction

   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [`CDS_SYNC_W-1:0] pins_lvl;
   logic scan_lvl;
   logic preset_n_lvl;
   logic zsd_lvl;
   logic ldc_lvl;
   logic ldr_lvl;
   cds_bcd_t cmp_bcd_lvl;
   cds_bcd_t cnt_bcd_lvl;

   cds_sync u_sync (
      .clk(clk),
      .reset(reset),
      .d({scan_in, scan_preset_n, zero_suppress_disable, load_counter,
          load_register, compare_bcd_in, counter_bcd_in}),
      .q(pins_lvl)
   );

   assign {scan_lvl, preset_n_lvl, zsd_lvl, ldc_lvl, ldr_lvl,
           cmp_bcd_lvl, cnt_bcd_lvl} = pins_lvl;

   logic scan_d_r;
   logic scan_rise;

   always_ff @(posedge clk) begin
      if (reset) begin
         scan_d_r <= 1'b0;
      end else begin
         scan_d_r <= scan_lvl;
      end
   end

   assign scan_rise = scan_lvl & ~scan_d_r;

   // ==========================================================
   // scan sequencer
   // ==========================================================
   cds_state_e state_r;
   cds_jc_t jc_r;
   logic [7:0] blank_cnt_r;
   logic blank_done;
   logic enter_show;
   logic leave_show;
   logic enter_blank;
   logic in_blank;
   logic show_next;
   logic [2:0] cur_idx;

   assign blank_done = blank_cnt_r == 8'(`CDS_BLANK_CYC - 1);
   assign enter_show = preset_n_lvl & (state_r == cds_st_intr) & blank_done;
   assign leave_show = preset_n_lvl & (state_r == cds_st_show) & ~scan_lvl;
   assign enter_blank = leave_show |
                        (preset_n_lvl & (state_r == cds_st_hold) & scan_rise);
   assign in_blank = (state_r == cds_st_low) | (state_r == cds_st_intr);
   assign show_next = enter_show |
                      (preset_n_lvl & (state_r == cds_st_show) & ~leave_show);
   assign cur_idx = jc_index(jc_r);

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= cds_st_preset;
         jc_r <= `CDS_JC_MSD;
         blank_cnt_r <= '0;
      end else if (!preset_n_lvl) begin
         state_r <= cds_st_preset; // [RQ6]
         jc_r <= `CDS_JC_MSD; // [RQ6]
         blank_cnt_r <= '0;
      end else begin
         case (state_r)
            cds_st_preset: begin
               state_r <= cds_st_hold; // [RQ7]
            end
            cds_st_hold: begin
               if (scan_rise) begin
                  jc_r <= jc_next(jc_r); // [RQ7]
                  blank_cnt_r <= '0;
                  state_r <= cds_st_intr;
               end
            end
            cds_st_low: begin
               if (scan_rise) begin
                  jc_r <= jc_next(jc_r); // [RQ4] [RQ5]
                  blank_cnt_r <= '0;
                  state_r <= cds_st_intr;
               end
            end
            cds_st_intr: begin
               // scan low dwell has passed; now the fixed part [RQ12]
               if (blank_done) begin
                  state_r <= cds_st_show;
               end else begin
                  blank_cnt_r <= blank_cnt_r + 8'h01;
               end
            end
            cds_st_show: begin
               if (!scan_lvl) begin
                  state_r <= cds_st_low; // [RQ12]
               end
            end
            default: begin
               state_r <= cds_st_preset;
            end
         endcase
      end
   end

   // ==========================================================
   // display outputs
   // ==========================================================
   logic [5:0] strobe_r;
   logic [6:0] segment_r;
   cds_bcd_t bcd_r;

   always_ff @(posedge clk) begin
      if (reset) begin
         strobe_r <= `CDS_STROBE_NONE;
      end else if (!preset_n_lvl) begin
         strobe_r <= `CDS_STROBE_ONE << `CDS_MSD_IDX; // [RQ6]
      end else if (enter_show) begin
         strobe_r <= `CDS_STROBE_ONE << cur_idx; // [RQ4]
      end else if (enter_blank) begin
         strobe_r <= `CDS_STROBE_NONE; // [RQ8]
      end
   end

   // only latch_data feeds the display; the register has no path here
   always_ff @(posedge clk) begin
      if (reset) begin
         bcd_r <= `CDS_BCD_ZERO;
      end else if (!preset_n_lvl) begin
         bcd_r <= digit_of(latch_data, `CDS_MSD_IDX); // [RQ6] [RQ3]
      end else if (enter_blank) begin
         bcd_r <= digit_of(latch_data, jc_index(jc_next(jc_r))); // [RQ10]
      end
   end

   // blanking and suppression act on segments only [RQ9]
   always_ff @(posedge clk) begin
      if (reset) begin
         segment_r <= `CDS_SEG_BLANK;
      end else if (!show_next) begin
         segment_r <= `CDS_SEG_BLANK; // [RQ6] [RQ8]
      end else if (!zsd_lvl && lead_zero(latch_data, cur_idx)) begin
         segment_r <= `CDS_SEG_BLANK; // [RQ9]
      end else begin
         segment_r <= seg7(digit_of(latch_data, cur_idx)); // [RQ3]
      end
   end

   // ==========================================================
   // decade loading
   // ==========================================================
   logic ldc_req_r;
   logic ldr_req_r;
   logic cnt_we_r;
   logic [2:0] cnt_digit_r;
   cds_bcd_t cnt_data_r;
   logic mem_we;

   // request caught as the strobe rises, data taken as it falls [RQ19]
   always_ff @(posedge clk) begin
      if (reset) begin
         ldc_req_r <= 1'b0;
         ldr_req_r <= 1'b0;
      end else if (enter_show) begin
         ldc_req_r <= ldc_lvl; // [RQ19]
         ldr_req_r <= ldr_lvl; // [RQ19] [RQ2]
      end else if (leave_show || !preset_n_lvl) begin
         ldc_req_r <= 1'b0;
         ldr_req_r <= 1'b0;
      end
   end

   assign mem_we = leave_show & ldr_req_r; // [RQ1]

   always_ff @(posedge clk) begin
      if (reset) begin
         cnt_we_r <= 1'b0;
         cnt_digit_r <= `CDS_LSD_IDX;
         cnt_data_r <= `CDS_BCD_ZERO;
      end else begin
         cnt_we_r <= leave_show & ldc_req_r; // [RQ1]
         if (leave_show && ldc_req_r) begin
            cnt_digit_r <= cur_idx;
            cnt_data_r <= cnt_bcd_lvl;
         end
      end
   end

   // ==========================================================
   // compare register and serial comparator
   // ==========================================================
   logic [2:0] sweep_r;
   logic [2:0] sweep_d_r;
   cds_bcd_t reg_digit;
   logic digit_ok;
   logic acc_r;
   logic match_r;

   cds_cmp_mem u_mem (
      .clk(clk),
      .reset(reset), // [RQ20]
      .wr_en(mem_we), // [RQ2]
      .wr_addr(cur_idx),
      .wr_data(cmp_bcd_lvl),
      .rd_addr(sweep_r),
      .rd_data(reg_digit)
   );

   // one decade per cycle keeps a single read port on the store
   assign digit_ok = reg_digit == digit_of(counter_value, sweep_d_r);

   always_ff @(posedge clk) begin
      if (reset) begin
         sweep_r <= `CDS_LSD_IDX;
         sweep_d_r <= `CDS_LSD_IDX;
         acc_r <= 1'b0;
         match_r <= 1'b0;
      end else begin
         sweep_r <= (sweep_r == `CDS_MSD_IDX) ? `CDS_LSD_IDX
                                               : sweep_r + 3'h1;
         sweep_d_r <= sweep_r;
         if (sweep_d_r == `CDS_LSD_IDX) begin
            acc_r <= digit_ok;
         end else begin
            acc_r <= acc_r & digit_ok;
         end
         if (sweep_d_r == `CDS_MSD_IDX) begin
            match_r <= acc_r & digit_ok; // [RQ17]
         end
      end
   end

   // ==========================================================
   // equal flag and load inhibit
   // ==========================================================
   logic load_any;
   logic load_d_r;
   logic inhibit_r;
   logic rel_pend_r;
   logic [6:0] gap_cnt_r;
   logic gap_ok;
   logic [4:0] settle_r;
   logic equal_r;

   assign load_any = ldc_lvl | ldr_lvl;
   assign gap_ok = gap_cnt_r == 7'(`CDS_LOAD_SETUP_CYC);

   always_ff @(posedge clk) begin
      if (reset) begin
         load_d_r <= 1'b0;
      end else begin
         load_d_r <= load_any;
      end
   end

   // a load that is still high wins over any release
   always_ff @(posedge clk) begin
      if (reset) begin
         inhibit_r <= 1'b0;
         rel_pend_r <= 1'b0;
      end else if (load_any) begin
         inhibit_r <= 1'b1; // [RQ18]
         rel_pend_r <= 1'b0;
      end else if (load_d_r) begin
         rel_pend_r <= 1'b1; // [RQ18]
      end else if (rel_pend_r && enter_show && gap_ok) begin
         inhibit_r <= 1'b0; // [RQ14]
         rel_pend_r <= 1'b0;
      end
   end

   // time spent in blanking since the load fell; restarts each strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         gap_cnt_r <= '0;
      end else if (!rel_pend_r || !in_blank) begin
         gap_cnt_r <= '0; // [RQ14]
      end else if (!gap_ok) begin
         gap_cnt_r <= gap_cnt_r + 7'h01;
      end
   end

   // judged once the counter has settled, held for the count period
   always_ff @(posedge clk) begin
      if (reset) begin
         equal_r <= 1'b0;
         settle_r <= '0;
      end else if (count_edge) begin
         equal_r <= 1'b0;
         settle_r <= 5'(`CDS_EQ_SETTLE_CYC);
      end else if (settle_r == 5'h01) begin
         equal_r <= match_r & ~inhibit_r & ~load_any; // [RQ17] [RQ18]
         settle_r <= '0;
      end else if (settle_r != 5'h00) begin
         settle_r <= settle_r - 5'h01;
      end
   end

   // ==========================================================
   // output ports
   // ==========================================================
   assign digit_strobe = strobe_r;
   assign segment = segment_r;
   assign bcd_out = bcd_r;
   assign equal_flag = equal_r;
   assign counter_load_we = cnt_we_r;
   assign counter_load_digit = cnt_digit_r;
   assign counter_load_data = cnt_data_r;
endmodule

// [testbench/cds_scan_sva.sv]
// assertion checker for the digit scan, display and equal outputs
`timescale 1ns/1ps
module cds_scan_sva (
   input wire logic clk,
   input wire logic reset,
   input wire logic scan_in,
   input wire logic scan_preset_n,
   input wire logic load_counter,
   input wire logic load_register,
   input wire logic [23:0] latch_data,
   input wire logic count_edge,
   input wire logic [5:0] digit_strobe,
   input wire logic [6:0] segment,
   input wire cds_pkg::cds_bcd_t bcd_out,
   input wire logic equal_flag,
   input wire logic counter_load_we,
   input wire logic [2:0] counter_load_digit
);
   import cds_pkg::*;
   // ==========================================================
   // level counters; pins pass a synchroniser before they act
   logic [3:0] pl_cnt, ph_cnt, ld_cnt;
   logic [4:0] ce_cnt;
   logic [5:0] last_r, nxt_strobe;
   logic held_r;
   always_ff @(posedge clk) begin
      if (reset) begin
         pl_cnt <= 4'h0;
         ph_cnt <= 4'h0;
         ld_cnt <= 4'h0;
         ce_cnt <= 5'h1f;
         last_r <= 6'h00;
         // reset parks the scan on the top decade with dark segments
         held_r <= 1'b1;
      end else begin
         pl_cnt <= scan_preset_n ? 4'h0 : pl_cnt + {3'h0, pl_cnt != 4'hf};
         ph_cnt <= !scan_preset_n ? 4'h0 : ph_cnt + {3'h0, ph_cnt != 4'hf};
         ld_cnt <= !(load_counter || load_register) ? 4'h0 :
            ld_cnt + {3'h0, ld_cnt != 4'hf};
         ce_cnt <= count_edge ? 5'h00 : ce_cnt + {4'h0, ce_cnt != 5'h1f};
         if (|digit_strobe) begin
            last_r <= digit_strobe;
         end
         if (pl_cnt >= 4'h7) begin
            held_r <= 1'b1;
         end else if (digit_strobe == 6'h00) begin
            held_r <= 1'b0;
         end
      end
   end
   assign nxt_strobe = (last_r <= 6'h01) ? 6'h20 : (last_r >> 1);

   // ==========================================================
   // properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   strobe_hot_a: assert property ($onehot0(digit_strobe))
      else $error("two digit strobes active");
   blank_dark_a: assert property (
      digit_strobe == 6'h00 |-> segment == 7'h00)
      else $error("segments lit with no strobe");
   bcd_steady_a: assert property (
      ph_cnt >= 4'h8 && (|digit_strobe) && (|$past(digit_strobe)) |->
      $stable(bcd_out)) else $error("bcd changed under a strobe");
   scan_order_a: assert property (
      ph_cnt >= 4'h8 && $rose(|digit_strobe) |-> digit_strobe == nxt_strobe)
      else $error("strobe out of scan order");
   preset_msd_a: assert property (pl_cnt >= 4'h7 |->
      digit_strobe == 6'h20 && segment == 7'h00 &&
      bcd_out == latch_data[23:20]) else $error("preset not on top decade");
   release_hold_a: assert property (
      (pl_cnt >= 4'h7 && !scan_in) ##1 (scan_preset_n && !scan_in) [*8] |->
      digit_strobe == 6'h20 && segment == 7'h00) else $error("hold left early");
   zero_blank_a: assert property (
      (|digit_strobe) && !held_r && ph_cnt >= 4'h8 && bcd_out != 4'h0 |->
      segment != 7'h00) else $error("nonzero decade shown dark");
   eq_clear_a: assert property (count_edge |=> !equal_flag)
      else $error("equal not cleared by count edge");
   eq_rise_a: assert property (
      $rose(equal_flag) |-> ce_cnt >= 5'h0e && ce_cnt <= 5'h12)
      else $error("equal rose off its slot");
   load_inhibit_a: assert property (
      count_edge && ld_cnt >= 4'h6 |=>
      (!equal_flag) [*8] ##1 (!equal_flag) [*8] ##1 !equal_flag)
      else $error("equal raised during a load");
   load_pulse_a: assert property (counter_load_we |->
      digit_strobe == 6'h00 &&
      $past(digit_strobe) == 6'h01 << counter_load_digit
      ##1 !counter_load_we) else $error("counter load off a strobe fall");
endmodule

bind cds_scan_top cds_scan_sva u_sva (.clk, .reset, .scan_in, .scan_preset_n,
   .load_counter, .load_register, .latch_data, .count_edge, .digit_strobe,
   .segment, .bcd_out, .equal_flag, .counter_load_we, .counter_load_digit);

// [testbench/cds_far_model.sv]
// far side model: thumbwheel diode matrix and display receiver
`timescale 1ns/1ps
module cds_far_model (
   input wire logic clk,
   input wire logic [5:0] digit_strobe,
   input wire cds_pkg::cds_bcd_t bcd_out,
   input wire logic [23:0] cmp_wheel,
   input wire logic [23:0] cnt_wheel,
   output cds_pkg::cds_bcd_t compare_bcd_in,
   output cds_pkg::cds_bcd_t counter_bcd_in,
   output logic [23:0] shown
);
   import cds_pkg::*;
   logic [5:0] strobe_q;
   // only the strobed decade drives; the pins pull low otherwise
   always_comb begin
      compare_bcd_in = 4'h0;
      counter_bcd_in = 4'h0;
      for (int k = 0; k < 6; k++) begin
         if (digit_strobe[k]) begin
            compare_bcd_in = cmp_wheel[4*k +: 4];
            counter_bcd_in = cnt_wheel[4*k +: 4];
         end
      end
   end
   always_ff @(posedge clk) begin
      strobe_q <= digit_strobe;
      for (int k = 0; k < 6; k++) begin
         if (digit_strobe[k] && !strobe_q[k]) begin
            shown[4*k +: 4] <= bcd_out;
         end
      end
   end
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the compare register and digit scan section
`timescale 1ns/1ps
module tb_top;
   import cds_pkg::*;
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic scan_in = 1'b0;
   logic scan_preset_n = 1'b1;
   logic zero_suppress_disable = 1'b0;
   logic load_counter = 1'b0;
   logic load_register = 1'b0;
   logic count_edge = 1'b0;
   logic [23:0] latch_data = 24'h00_8010;
   logic [23:0] counter_value = 24'h00_0000;
   logic [23:0] cmp_wheel = 24'h12_3456;
   logic [23:0] cnt_wheel = 24'h65_4321;
   logic [23:0] shown, got_cnt;
   logic [5:0] digit_strobe;
   logic [6:0] segment;
   logic equal_flag, counter_load_we;
   logic [2:0] counter_load_digit;
   cds_bcd_t compare_bcd_in, counter_bcd_in, bcd_out, counter_load_data;
   int error_cnt = 0;
   int compares = 0;
   int we_cnt = 0;

   always #12.5 clk = ~clk;

   cds_scan_top uut (.clk, .reset, .scan_in, .scan_preset_n,
      .zero_suppress_disable, .load_counter, .load_register, .compare_bcd_in,
      .counter_bcd_in, .latch_data, .counter_value, .count_edge, .digit_strobe,
      .segment, .bcd_out, .equal_flag, .counter_load_we, .counter_load_digit,
      .counter_load_data);
   cds_far_model far (.clk, .digit_strobe, .bcd_out, .cmp_wheel, .cnt_wheel,
      .compare_bcd_in, .counter_bcd_in, .shown);

   always @(posedge clk) begin
      if (counter_load_we === 1'b1) begin
         we_cnt++;
         got_cnt[counter_load_digit * 4 +: 4] <= counter_load_data;
      end
   end

   // ==========================================================
   // shared tasks
   task automatic finish_test;
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic check(input string what, input logic [23:0] seen,
         input logic [23:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic pulse_count(input logic [23:0] val);
      counter_value <= val;
      count_edge <= 1'b1; // no carry here, one cycle will do
      cyc(1);
      count_edge <= 1'b0;
      cyc(20); // equal flag settles before the next count
   endtask
   // one scan period: 250 high, 20 low; strobe needs 200 blank cycles
   task automatic scan_digit(input int d, input logic lit);
      logic [3:0] v;
      v = latch_data[4*d +: 4];
      scan_in <= 1'b1;
      cyc(190);
      check("blank strobe", digit_strobe, 6'h00);
      cyc(60);
      check("strobe", digit_strobe, 6'h01 << d);
      check("bcd", bcd_out, v);
      if (!lit) check("seg dark", segment, 7'h00);
      else if (v == 4'h8) check("seg eight", segment, 7'h7f);
      else check("seg lit", segment == 7'h00, 1'b0);
      scan_in <= 1'b0;
      cyc(12);
      check("gap strobe", digit_strobe, 6'h00);
      check("gap seg", segment, 7'h00);
      check("next bcd", bcd_out, latch_data[4*((d+5)%6) +: 4]);
      cyc(8);
   endtask
   // decades 5 and 4 of the latch are the leading zeros
   // disable passed in: a fresh nonblocking write is not yet visible here
   task automatic sweep(input logic zsd);
      for (int i = 0; i < 6; i++) begin
         scan_digit((10 - i) % 6, zsd || (10 - i) % 6 < 4);
      end
   endtask

   // ==========================================================
   // scenarios
   task automatic t_load_reg;
      load_register <= 1'b1;
      sweep(1'b0);
      check("stray counter loads", we_cnt, 0);
      check("shown", shown, latch_data);
      load_register <= 1'b0;
   endtask
   task automatic t_plain;
      zero_suppress_disable <= 1'b1;
      sweep(1'b1);
   endtask
   task automatic t_equal;
      logic [23:0] vals [3];
      vals = '{24'h12_3456, 24'h12_3457, 24'h02_3456};
      foreach (vals[i]) begin
         pulse_count(vals[i]);
         check("equal", equal_flag, i == 0);
      end
   endtask
   task automatic t_counter_load;
      int base;
      base = we_cnt;
      load_counter <= 1'b1;
      cyc(10);
      pulse_count(24'h12_3456);
      check("equal under load", equal_flag, 1'b0);
      sweep(1'b1);
      check("counter loads", we_cnt - base, 6);
      check("counter load data", got_cnt, cnt_wheel);
      load_counter <= 1'b0;
      sweep(1'b1);
   endtask
   task automatic t_preset;
      scan_preset_n <= 1'b0;
      cyc(10);
      check("preset strobe", digit_strobe, 6'h20);
      check("preset seg", segment, 7'h00);
      check("preset bcd", bcd_out, latch_data[23:20]);
      scan_preset_n <= 1'b1;
      cyc(20);
      check("hold strobe", digit_strobe, 6'h20);
      scan_digit(4, 1'b1);
   endtask

   initial begin
      cyc(6);
      reset <= 1'b0;
      cyc(10);
      t_load_reg;
      t_plain;
      t_equal;
      t_counter_load;
      t_equal;
      t_preset;
      finish_test;
   end

   // four sweeps of about 1620 cycles each, with ample margin
   initial begin
      cyc(20000);
      error_cnt++;
      finish_test;
   end
endmodule
